// File: shared/idp_pkg.sv
// Constants shared by the identify parameter block responder
package idp_pkg;

   // ------------------------------------------------------------
   // Task-file and configuration register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] REG_DATA      = 4'h0;
   localparam logic [3:0] REG_FEATURE   = 4'h1;
   localparam logic [3:0] REG_SECCOUNT  = 4'h2;
   localparam logic [3:0] REG_SECNUM    = 4'h3;
   localparam logic [3:0] REG_CYLLOW    = 4'h4;
   localparam logic [3:0] REG_CYLHIGH   = 4'h5;
   localparam logic [3:0] REG_DRVHEAD   = 4'h6;
   localparam logic [3:0] REG_COMMAND   = 4'h7;
   localparam logic [3:0] REG_STATUS    = 4'h7;
   localparam logic [3:0] REG_CFG_DMA   = 4'h8;
   localparam logic [3:0] REG_CFG_UDMA  = 4'h9;
   localparam logic [3:0] REG_CFG_MULT  = 4'hA;
   localparam logic [3:0] REG_STR_ADDR  = 4'hB;
   localparam logic [3:0] REG_STR_DATA  = 4'hC;

   // ------------------------------------------------------------
   // Commands and status bits
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_IDENTIFY  = 8'hEC;
   localparam logic [7:0] CMD_SET_MULT  = 8'hC6;
   localparam int         STS_BUSY      = 7;
   localparam int         STS_READY     = 6;
   localparam int         STS_DRQ       = 3;

   // ------------------------------------------------------------
   // Fixed parameter block words
   // ------------------------------------------------------------
   localparam logic [15:0] W_GENCFG     = 16'h044A;
   localparam logic [15:0] W_RSVD5      = 16'h0200;
   localparam logic [15:0] W_BUFTYPE    = 16'h0002;
   localparam logic [15:0] W_MULTMAX    = 16'h8001;
   localparam logic [15:0] W_CAPAB      = 16'h0B00;
   localparam logic [15:0] W_PIOMODE    = 16'h0200;
   localparam logic [15:0] W_VALID      = 16'h0007;
   localparam logic [7:0]  W59_FLAG     = 8'h01;
   localparam logic [7:0]  MULT_RESET   = 8'h00;
   localparam logic [7:0]  DMA_SUPPORT  = 8'h07;
   localparam logic [15:0] W_PIOADV     = 16'h0003;
   localparam logic [15:0] W_CYCLE      = 16'h0078;
   localparam logic [15:0] W_MAJOR      = 16'h007E;
   localparam logic [15:0] W_MINOR      = 16'h0019;
   localparam logic [15:0] W_FEAT82     = 16'h706B;
   localparam logic [15:0] W_FEAT83     = 16'h400C;
   localparam logic [15:0] W_FEAT84     = 16'h4000;
   localparam logic [7:0]  UDMA_SUPPORT = 8'h1F;
   localparam logic [7:0]  DMA_SEL_RST  = 8'h04;
   localparam logic [7:0]  UDMA_SEL_RST = 8'h00;
   localparam logic [7:0]  ASCII_SPACE  = 8'h20;

   // ------------------------------------------------------------
   // String area in the programmable byte store
   // ------------------------------------------------------------
   localparam int          STR_BYTES    = 68;
   localparam logic [6:0]  SER_BASE     = 7'h00;
   localparam logic [6:0]  FW_BASE      = 7'h14;
   localparam logic [6:0]  MODEL_BASE   = 7'h1C;
   localparam logic [7:0]  WORD_LAST    = 8'hFF;

endpackage

// File: hw/idp_identify_block.sv
// Identify command handler returning the 256-word parameter block
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module idp_identify_block
   import idp_pkg::*;
#(
   parameter logic [15:0] DEF_CYLS   = 16'h03D6,
   parameter logic [15:0] DEF_HEADS  = 16'h0010,
   parameter logic [15:0] DEF_SPT    = 16'h003F,
   parameter logic [15:0] BUF_SIZE   = 16'h0001,
   parameter logic [15:0] ECC_BYTES  = 16'h0004,
   // Arbitrary vendor word
   parameter logic [15:0] VENDOR_WORD = 16'h0000
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdData,
   output logic             dataRequest,
   output logic             cmdBusy
);

   // ------------------------------------------------------------
   // Task-file and configuration registers
   // ------------------------------------------------------------
   logic [7:0]  featureSelect_reg;
   logic [7:0]  sectorCount_reg;
   logic [7:0]  sectorNumber_reg;
   logic [7:0]  cylLow_reg;
   logic [7:0]  cylHigh_reg;
   logic [7:0]  driveHead_reg;
   logic [7:0]  dmaSelect_reg;
   logic [7:0]  udmaSelect_reg;
   logic [7:0]  multCount_reg;
   logic [6:0]  strAddr_reg;
   logic [7:0]  strMem [STR_BYTES];
   logic [15:0] regRdData_reg;

   typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_XFER} idp_state_t;
   idp_state_t  state_reg;
   idp_state_t  state_next;
   logic [7:0]  wordIdx_reg;
   logic [7:0]  wordIdx_next;

   wire wrCmd  = regWrite && regAddr == REG_COMMAND;
   wire rdData = regRead && regAddr == REG_DATA && state_reg == ST_XFER;
   wire [31:0] totalSectors = 32'(DEF_CYLS) * 32'(DEF_HEADS) * 32'(DEF_SPT);

   function automatic logic [15:0] strWord(input logic [6:0] base, input logic [7:0] off);
      logic [6:0] b;
      b = base + 7'({off[6:0], 1'b0});
      return {strMem[b], strMem[7'(b + 7'h01)]};
   endfunction

   // ------------------------------------------------------------
   // Parameter block word decode
   // ------------------------------------------------------------
   logic [15:0] blockWord;
   always_comb begin
      // Unlisted words are reserved and read zero
      // reserved read zero
      blockWord = 16'h0000;
      unique case (wordIdx_reg) inside
         8'd0:          blockWord = W_GENCFG;
         8'd1:          blockWord = DEF_CYLS;
         8'd3:          blockWord = DEF_HEADS;
         8'd5:          blockWord = W_RSVD5;
         8'd6:          blockWord = DEF_SPT;
         8'd7:          blockWord = totalSectors[31:16];
         8'd8:          blockWord = totalSectors[15:0];
         8'd9:          blockWord = VENDOR_WORD;
         [8'd10:8'd19]: blockWord = strWord(SER_BASE, wordIdx_reg - 8'd10);
         8'd20:         blockWord = W_BUFTYPE;
         8'd21:         blockWord = BUF_SIZE;
         8'd22:         blockWord = ECC_BYTES;
         [8'd23:8'd26]: blockWord = strWord(FW_BASE, wordIdx_reg - 8'd23);
         [8'd27:8'd46]: blockWord = strWord(MODEL_BASE, wordIdx_reg - 8'd27);
         8'd47:         blockWord = W_MULTMAX;
         8'd49:         blockWord = W_CAPAB;
         8'd51:         blockWord = W_PIOMODE;
         8'd53:         blockWord = W_VALID;
         8'd54:         blockWord = DEF_CYLS;
         8'd55:         blockWord = DEF_HEADS;
         8'd56:         blockWord = DEF_SPT;
         8'd57:         blockWord = totalSectors[15:0];
         8'd58:         blockWord = totalSectors[31:16];
         8'd59:         blockWord = {W59_FLAG, multCount_reg};
         8'd60:         blockWord = totalSectors[15:0];
         8'd61:         blockWord = totalSectors[31:16];
         8'd63:         blockWord = {dmaSelect_reg, DMA_SUPPORT};
         8'd64:         blockWord = W_PIOADV;
         [8'd65:8'd68]: blockWord = W_CYCLE;
         8'd80:         blockWord = W_MAJOR;
         8'd81:         blockWord = W_MINOR;
         8'd82:         blockWord = W_FEAT82;
         8'd83:         blockWord = W_FEAT83;
         8'd84:         blockWord = W_FEAT84;
         8'd88:         blockWord = {udmaSelect_reg, UDMA_SUPPORT};
         default:       blockWord = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // Command sequencing, like a one-sector read
   // ------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      wordIdx_next = wordIdx_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (wrCmd && regWrData[7:0] == CMD_IDENTIFY) begin
               state_next   = ST_BUSY;
               wordIdx_next = 8'h00;
            end
         end
         ST_BUSY: state_next = ST_XFER;
         ST_XFER: begin
            if (rdData) begin
               wordIdx_next = wordIdx_reg + 8'h01;
               if (wordIdx_reg == WORD_LAST) begin
                  state_next = ST_IDLE;
               end
            end
         end
      endcase
   end

   wire [7:0] statusByte = {state_reg == ST_BUSY, state_reg != ST_BUSY, 1'b0, 1'b0,
                            state_reg == ST_XFER, 3'b000};

   logic [15:0] rdMux;
   assign rdMux = regAddr == REG_DATA     ? (rdData ? blockWord : 16'h0000) :
                  regAddr == REG_FEATURE  ? {8'h00, featureSelect_reg} :
                  regAddr == REG_SECCOUNT ? {8'h00, sectorCount_reg} :
                  regAddr == REG_SECNUM   ? {8'h00, sectorNumber_reg} :
                  regAddr == REG_CYLLOW   ? {8'h00, cylLow_reg} :
                  regAddr == REG_CYLHIGH  ? {8'h00, cylHigh_reg} :
                  regAddr == REG_DRVHEAD  ? {8'h00, driveHead_reg} :
                  regAddr == REG_STATUS   ? {8'h00, statusByte} :
                  regAddr == REG_CFG_DMA  ? {8'h00, dmaSelect_reg} :
                  regAddr == REG_CFG_UDMA ? {8'h00, udmaSelect_reg} :
                  regAddr == REG_CFG_MULT ? {8'h00, multCount_reg} :
                  regAddr == REG_STR_ADDR ? {9'h000, strAddr_reg} :
                  regAddr == REG_STR_DATA ? {8'h00, strMem[strAddr_reg]} : 16'h0000;

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg         <= ST_IDLE;
         wordIdx_reg       <= 8'h00;
         featureSelect_reg <= 8'h00;
         sectorCount_reg   <= 8'h00;
         sectorNumber_reg  <= 8'h00;
         cylLow_reg        <= 8'h00;
         cylHigh_reg       <= 8'h00;
         driveHead_reg     <= 8'h00;
         dmaSelect_reg     <= DMA_SEL_RST;
         udmaSelect_reg    <= UDMA_SEL_RST;
         multCount_reg     <= MULT_RESET;
         strAddr_reg       <= 7'h00;
         regRdData_reg     <= 16'h0000;
      end else begin
         state_reg     <= state_next;
         wordIdx_reg   <= wordIdx_next;
         regRdData_reg <= regRead ? rdMux : 16'h0000;
         if (regWrite) begin
            unique case (regAddr)
               REG_FEATURE:  featureSelect_reg <= regWrData[7:0];
               REG_SECCOUNT: sectorCount_reg   <= regWrData[7:0];
               REG_SECNUM:   sectorNumber_reg  <= regWrData[7:0];
               REG_CYLLOW:   cylLow_reg        <= regWrData[7:0];
               REG_CYLHIGH:  cylHigh_reg       <= regWrData[7:0];
               REG_DRVHEAD:  driveHead_reg     <= regWrData[7:0];
               REG_CFG_DMA:  dmaSelect_reg     <= regWrData[7:0];
               REG_CFG_UDMA: udmaSelect_reg    <= regWrData[7:0];
               REG_STR_ADDR: strAddr_reg       <= regWrData[6:0];
               REG_STR_DATA: strAddr_reg       <= strAddr_reg + 7'h01;
               default: ;
            endcase
            // Set-multiple latches the sector count
            if (wrCmd && regWrData[7:0] == CMD_SET_MULT && state_reg == ST_IDLE) begin
               multCount_reg <= sectorCount_reg;
            end
         end
      end
   end

   // String store: serial, firmware and model, all spaces after reset
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < STR_BYTES; i++) begin
         if (!reset_n) begin
            strMem[i] <= ASCII_SPACE;
         end else if (regWrite && regAddr == REG_STR_DATA && int'(strAddr_reg) == i) begin
            strMem[i] <= regWrData[7:0];
         end
      end
   end

   assign regRdData   = regRdData_reg;
   assign dataRequest = state_reg == ST_XFER;
   assign cmdBusy     = state_reg == ST_BUSY;

endmodule // idp_identify_block

// File: sim/idp_monitor.sv
// Port checker for the identify block
`timescale 1ns/1ps
module idp_monitor
   import idp_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic [3:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regRdData,
   input wire logic        dataRequest,
   input wire logic        cmdBusy
);
   logic [7:0] wordCnt_reg;
   logic       dataRd;
   logic       identWr;
   assign dataRd  = regRead && regAddr == REG_DATA && dataRequest;
   assign identWr = regWrite && regAddr == REG_COMMAND && regWrData[7:0] == CMD_IDENTIFY
                    && !dataRequest && !cmdBusy;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || cmdBusy) wordCnt_reg <= 8'h00;
      else if (dataRd) wordCnt_reg <= wordCnt_reg + 8'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_rd_answer_only: assert property (!$past(regRead) |-> regRdData == 16'h0000)
      else $error("read data outside answer cycle");
   a_ident_starts: assert property (identWr |=> cmdBusy)
      else $error("identify not taken");
   a_busy_cause: assert property ($rose(cmdBusy) |-> $past(identWr))
      else $error("busy without identify");
   a_busy_then_req: assert property (cmdBusy |=> dataRequest && !cmdBusy)
      else $error("busy pulse not followed by request");
   a_req_cause: assert property ($rose(dataRequest) |-> $past(cmdBusy))
      else $error("request without busy");
   a_req_holds: assert property (dataRequest && !(dataRd && wordCnt_reg == 8'hFF)
      |=> dataRequest) else $error("request dropped early");
   a_req_drop: assert property (dataRd && wordCnt_reg == 8'hFF |=> !dataRequest)
      else $error("request after last word");
   a_word_zero: assert property (dataRd && wordCnt_reg == 8'h00 |=> regRdData == 16'h044A)
      else $error("word 0 wrong");
   a_word_valid: assert property (dataRd && wordCnt_reg == 8'h35 |=> regRdData == 16'h0007)
      else $error("word 53 wrong");
   a_rsvd_zero: assert property (dataRd && wordCnt_reg inside {[8'h45:8'h4F], [8'hA4:8'hFF]}
      |=> regRdData == 16'h0000) else $error("reserved word not zero");
   a_idle_data: assert property (regRead && regAddr == REG_DATA && !dataRequest
      |=> regRdData == 16'h0000) else $error("idle data read not zero");
endmodule // idp_monitor

// File: sim/idp_host_model.sv
// Host controller model on the task-file register port
`timescale 1ns/1ps
module idp_host_model (
   input  wire logic        ref_clk,
   input  wire logic [15:0] regRdData,
   output logic      [3:0]  regAddr,
   output logic      [15:0] regWrData,
   output logic             regWrite,
   output logic             regRead
);
   initial begin
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge ref_clk);
      regWrite  <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      // Answer stands in the cycle after the strobe; sample it settled
      #1 v = regRdData;
   endtask
endmodule // idp_host_model

// File: sim/tb.sv
// Self-checking bench for the identify block
`timescale 1ns/1ps
module tb;
   import idp_pkg::*;
   localparam logic [15:0] CYL = 16'h03D6;
   localparam logic [15:0] HDS = 16'h0010;
   localparam logic [15:0] SPT = 16'h003F;
   localparam logic [31:0] CAP = CYL * HDS * SPT;
   localparam logic [23:0] ROWS [34] = '{
      24'h00044A, {8'h01, CYL}, {8'h03, HDS}, 24'h050200, {8'h06, SPT}, {8'h07, CAP[31:16]},
      {8'h08, CAP[15:0]}, 24'h140002, 24'h150001, 24'h160004, 24'h2F8001, 24'h310B00,
      24'h330200, 24'h350007, {8'h36, CYL}, {8'h37, HDS}, {8'h38, SPT}, {8'h39, CAP[15:0]},
      {8'h3A, CAP[31:16]}, 24'h3B0100, {8'h3C, CAP[15:0]}, {8'h3D, CAP[31:16]}, 24'h3F0407,
      24'h400003, 24'h410078, 24'h420078, 24'h430078, 24'h440078, 24'h50007E, 24'h510019,
      24'h52706B, 24'h53400C, 24'h544000, 24'h58001F};
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  regAddr;
   logic [15:0] regWrData;
   logic        regWrite;
   logic        regRead;
   logic [15:0] regRdData;
   logic        dataRequest;
   logic        cmdBusy;
   logic [15:0] expTab [256];
   logic [15:0] v;
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   always #2.5 ref_clk = ~ref_clk;
   idp_identify_block #(.DEF_CYLS(CYL), .DEF_HEADS(HDS), .DEF_SPT(SPT)) DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .dataRequest(dataRequest), .cmdBusy(cmdBusy));
   idp_host_model host (
      .ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead));
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic fillTab;
      for (int i = 0; i < 256; i++) expTab[i] = (i >= 10 && i <= 46) ? 16'h2020 : 16'h0000;
      for (int r = 0; r < 34; r++) expTab[ROWS[r][23:16]] = ROWS[r][15:0];
   endtask
   task automatic ident(input int skip);
      host.wr(REG_COMMAND, {8'h00, CMD_IDENTIFY});
      #1 chk("busy", {15'h0000, cmdBusy}, 16'h0001);
      @(posedge ref_clk);
      #1 chk("request", {15'h0000, dataRequest}, 16'h0001);
      for (int k = 0; k < 256; k++) begin
         if (k == skip) begin
            host.rd(REG_STATUS, v);
            chk("status", {15'h0000, v[STS_DRQ]}, 16'h0001);
            host.wr(REG_COMMAND, {8'h00, CMD_IDENTIFY});
         end
         host.rd(REG_DATA, v);
         chk($sformatf("word %0d", k), v, expTab[k]);
      end
      @(posedge ref_clk);
      #1 chk("request end", {15'h0000, dataRequest}, 16'h0000);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         errors++;
         tally_and_finish;
      end
   end
   initial begin
      fillTab();
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1 chk("reset request", {15'h0000, dataRequest}, 16'h0000);
      host.rd(REG_DATA, v);
      chk("idle data", v, 16'h0000);
      host.rd(4'hF, v);
      chk("unmapped", v, 16'h0000);
      ident(300);
      // Reconfigure selects, multiple count and strings
      host.wr(REG_SECCOUNT, 16'h0008);
      host.wr(REG_COMMAND, {8'h00, CMD_SET_MULT});
      host.wr(REG_CFG_DMA, 16'h0002);
      host.wr(REG_CFG_UDMA, 16'h0004);
      host.wr(REG_STR_ADDR, 16'h0000);
      host.wr(REG_STR_DATA, 16'h0041);
      host.wr(REG_STR_DATA, 16'h0042);
      host.wr(REG_STR_ADDR, 16'h0014);
      host.wr(REG_STR_DATA, 16'h0058);
      host.rd(REG_CFG_MULT, v);
      chk("multiple", v, 16'h0008);
      expTab[59] = 16'h0108;
      expTab[63] = 16'h0207;
      expTab[88] = 16'h041F;
      expTab[10] = 16'h4142;
      expTab[23] = 16'h5820;
      ident(5);
      // Reset in the middle of a transfer
      host.wr(REG_COMMAND, {8'h00, CMD_IDENTIFY});
      repeat (3) host.rd(REG_DATA, v);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk("abort request", {15'h0000, dataRequest}, 16'h0000);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      host.rd(REG_CFG_MULT, v);
      chk("multiple reset", v, 16'h0000);
      fillTab();
      ident(300);
      tally_and_finish;
   end
endmodule // tb
bind idp_identify_block idp_monitor u_mon (
   .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .dataRequest(dataRequest), .cmdBusy(cmdBusy));
